// ### verilog/cfg_regbank.sv
// converter configuration register bank with channel index steering
//
// Implementation choice: strobed register access.
`default_nettype none
module cfg_regbank
  import cfg_pkg::*;
(
  input  wire logic CORE_CLK,           // register clock
  input  wire logic RST_B,              // async reset, active low
  cfg_if.dev        BUS,                // register access port
  output logic [2:0] SER_MODE,          // serialization mode
  output logic [1:0] CHAN_PWDN,         // per channel power-down
  output logic [1:0] CHAN_ORST,         // per channel output reset
  output logic [1:0] CLK_ORST,          // data_clock_out, frame_clock_out reset
  output logic       RECOVERY_EN,       // clock recovery active
  output logic       REF_DRIVE_EXT,     // drive reference externally
  output logic [1:0] REF_LEVEL,         // internal reference level
  output logic [1:0] POWER_MODE,        // power mode field
  output logic       CAL_BUSY           // foreground calibration running
);
  logic [7:0] idx_q, pm_q, ser_q, io2_q, io3_q, clkmon_q, ref_q, cal_q, rdata_q;
  logic [7:0] cs_q [4];  // per target: chan A, chan B, frame clk, data clk
  logic [7:0] cal_cnt_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire wr = BUS.req & BUS.we;
  wire rd = BUS.req & ~BUS.we;
  wire [3:0] tgt = {idx_q[IDX_DCO_BIT], idx_q[IDX_FCO_BIT], idx_q[1:0]};

  // write enables; calibration status has none, so writes fall away
  wire idx_wr    = wr & (BUS.addr == OFS_CHAN_INDEX);
  wire pm_wr     = wr & (BUS.addr == OFS_POWER_MODE);
  wire ser_wr    = wr & (BUS.addr == OFS_SER_OUT_CTL);
  wire cs_wr     = wr & (BUS.addr == OFS_CHAN_STATUS);
  wire io2_wr    = wr & (BUS.addr == OFS_USER_IO_TWO);
  wire io3_wr    = wr & (BUS.addr == OFS_USER_IO_THR);
  wire clkmon_wr = wr & (BUS.addr == OFS_CLK_MON_CTL);
  wire ref_wr    = wr & (BUS.addr == OFS_REF_CTL);

  // lowest selected target: chan A, chan B, frame clk, data clk
  function automatic logic [1:0] first_target(input logic [3:0] sel);
    logic [1:0] pick;
    pick = 2'h3;
    for (int i = 3; i >= 0; i--)
    begin
      if (sel[i])
        pick = 2'(i);
    end
    return pick;
  endfunction
  // first selected target supplies the read of a local register
  wire [1:0] rd_sel = first_target(tgt);

  // ---------------------------------------------------------------
  // global registers, written whatever the index holds
  // ---------------------------------------------------------------
  // channel index, steers the local writes
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      idx_q <= RST_CHAN_INDEX;
    else if (idx_wr)
      idx_q <= BUS.wdata;
  end

  // power mode
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      pm_q <= RST_POWER_MODE;
    else if (pm_wr)
      pm_q <= BUS.wdata;
  end

  // serial output control
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      ser_q <= RST_SER_OUT_CTL;
    else if (ser_wr)
      ser_q <= BUS.wdata;
  end

  // user io control two
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      io2_q <= RST_USER_IO;
    else if (io2_wr)
      io2_q <= BUS.wdata;
  end

  // user io control three
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      io3_q <= RST_USER_IO;
    else if (io3_wr)
      io3_q <= BUS.wdata;
  end

  // clock monitor control
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      clkmon_q <= RST_CLK_MON_CTL;
    else if (clkmon_wr)
      clkmon_q <= BUS.wdata;
  end

  // reference control
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      ref_q <= RST_REF_CTL;
    else if (ref_wr)
      ref_q <= BUS.wdata;
  end

  // ---------------------------------------------------------------
  // local channel status, one copy per target
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_cs
      always_ff @(posedge CORE_CLK or negedge RST_B)
      begin
        if (!RST_B)
          cs_q[g] <= RST_CHAN_STATUS;
        else if (cs_wr && tgt[g])
          cs_q[g] <= BUS.wdata;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // foreground calibration after a digital reset
  // ---------------------------------------------------------------
  wire dig_rst = pm_wr & (BUS.wdata[1:0] == PM_DIG_RST);
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cal_cnt_q <= CAL_CYCLES;  // calibration runs at power-up
      cal_q     <= 8'h03;
    end
    else if (dig_rst)
    begin
      cal_cnt_q <= CAL_CYCLES;
      cal_q     <= 8'h03;
    end
    else if (cal_cnt_q != 8'h00)
      cal_cnt_q <= cal_cnt_q - 8'h01;
    else
      cal_q     <= 8'h00;
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  logic [7:0] rmux;
  always_comb
  begin
    case (BUS.addr)
      OFS_CHAN_INDEX:  rmux = idx_q;
      OFS_POWER_MODE:  rmux = pm_q;
      OFS_SER_OUT_CTL: rmux = ser_q;
      OFS_CHAN_STATUS: rmux = cs_q[rd_sel];
      OFS_USER_IO_TWO: rmux = io2_q;
      OFS_USER_IO_THR: rmux = io3_q;
      OFS_CAL_STATUS:  rmux = cal_q;
      OFS_CLK_MON_CTL: rmux = clkmon_q;
      OFS_REF_CTL:     rmux = ref_q;
      default:         rmux = 8'h00;
    endcase
  end
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      rdata_q <= 8'h00;
    else if (rd)
      rdata_q <= rmux;
  end
  assign BUS.rdata = rdata_q;

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign SER_MODE      = ser_q[SER_MODE_LSB +: 3];
  assign CHAN_PWDN     = {cs_q[1][CS_PWDN_BIT], cs_q[0][CS_PWDN_BIT]};
  assign CHAN_ORST     = {cs_q[1][CS_ORST_BIT], cs_q[0][CS_ORST_BIT]};
  assign CLK_ORST      = {cs_q[3][CS_ORST_BIT], cs_q[2][CS_ORST_BIT]};
  assign RECOVERY_EN   = clkmon_q[RECOVERY_LSB +: 3] == RECOVERY_ON;
  assign REF_DRIVE_EXT = ref_q[REF_DRIVE_BIT];
  assign REF_LEVEL     = ref_q[1:0];
  assign POWER_MODE    = pm_q[1:0];
  assign CAL_BUSY      = cal_q != 8'h00;
endmodule // cfg_regbank
`default_nettype wire

// ### verilog/cfg_pkg.sv
// shared constants for the converter configuration register bank
`default_nettype none
package cfg_pkg;
  // register offsets
  localparam logic [9:0] OFS_CHAN_INDEX   = 10'h005;
  localparam logic [9:0] OFS_POWER_MODE   = 10'h008;
  localparam logic [9:0] OFS_SER_OUT_CTL  = 10'h021;
  localparam logic [9:0] OFS_CHAN_STATUS  = 10'h022;
  localparam logic [9:0] OFS_USER_IO_TWO  = 10'h101;
  localparam logic [9:0] OFS_USER_IO_THR  = 10'h102;
  localparam logic [9:0] OFS_CAL_STATUS   = 10'h107;
  localparam logic [9:0] OFS_CLK_MON_CTL  = 10'h112;
  localparam logic [9:0] OFS_REF_CTL      = 10'h114;
  // reset values
  localparam logic [7:0] RST_CHAN_INDEX   = 8'h33;
  localparam logic [7:0] RST_POWER_MODE   = 8'h00;
  localparam logic [7:0] RST_SER_OUT_CTL  = 8'h30;
  localparam logic [7:0] RST_CHAN_STATUS  = 8'h00;
  localparam logic [7:0] RST_USER_IO      = 8'h00;
  localparam logic [7:0] RST_CLK_MON_CTL  = 8'h07;
  localparam logic [7:0] RST_REF_CTL      = 8'h00;
  // field positions
  localparam int SER_MODE_LSB  = 4;
  localparam int RECOVERY_LSB  = 3;
  localparam int REF_DRIVE_BIT = 2;
  localparam int CS_PWDN_BIT   = 0;
  localparam int CS_ORST_BIT   = 2;
  localparam int IDX_DCO_BIT   = 5;
  localparam int IDX_FCO_BIT   = 4;
  // field values
  localparam logic [2:0] RECOVERY_OFF = 3'h0;
  localparam logic [2:0] RECOVERY_ON  = 3'h5;
  localparam logic [1:0] PM_NORMAL    = 2'h0;
  localparam logic [1:0] PM_PWDN      = 2'h1;
  localparam logic [1:0] PM_STANDBY   = 2'h2;
  localparam logic [1:0] PM_DIG_RST   = 2'h3;
  localparam logic [7:0] IDX_CHAN_B   = 8'h02;
  localparam logic [7:0] IDX_CLK_A    = 8'h31;
  localparam logic [7:0] CS_PWDN_VAL  = 8'h01;
  localparam logic [7:0] PM_RST_VAL   = 8'h03;
  // cycles of foreground calibration after a digital reset
  localparam logic [7:0] CAL_CYCLES   = 8'h40;
  // controller host register offsets
  localparam logic [3:0] HOST_CMD     = 4'h0;
  localparam logic [3:0] HOST_STATUS  = 4'h1;
  localparam logic [3:0] HOST_IRQ     = 4'h2;
  localparam logic [3:0] HOST_MASK    = 4'h3;
  localparam logic [3:0] HOST_RDATA   = 4'h4;
  localparam logic [3:0] HOST_ADDR    = 4'h5;
  localparam logic [3:0] HOST_WDATA   = 4'h6;
  // serialization modes
  typedef enum logic [2:0] {
    SER_SDR2_BIT  = 3'h0,
    SER_SDR2_BYTE = 3'h1,
    SER_DDR2_BIT  = 3'h2,
    SER_DDR2_BITB = 3'h3,
    SER_DDR1_WORD = 3'h4
  } ser_mode_t;
endpackage
`default_nettype wire

// ### verilog/cfg_if.sv
// register access link between controller and converter register bank
`default_nettype none
interface cfg_if;
  logic       req;    // access strobe
  logic       we;     // write when high
  logic [9:0] addr;   // register offset
  logic [7:0] wdata;  // write data
  logic [7:0] rdata;  // read data, cycle after req
  modport dev  (input req, we, addr, wdata, output rdata);
  modport ctrl (output req, we, addr, wdata, input rdata);
endinterface
`default_nettype wire

// ### verilog/cfg_ctrl.sv
// host-side controller issuing register accesses and the channel power-down sequence
`default_nettype none
module cfg_ctrl
  import cfg_pkg::*;
(
  input  wire logic       CORE_CLK,  // clock
  input  wire logic       RST_B,     // async reset, active low
  input  wire logic [3:0] ADDR,      // host register address
  input  wire logic [7:0] WDATA,     // host write data
  input  wire logic       WR,        // write strobe
  input  wire logic       RD,        // read strobe
  output logic      [7:0] RDATA,     // read data, cycle after RD
  output logic            IRQ,       // level interrupt
  cfg_if.ctrl             LINK       // register access link
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_IDXB = 3'b001, S_PWDN = 3'b011, S_IDXA = 3'b010,
    S_RST  = 3'b110, S_NORM = 3'b111, S_POLL = 3'b101, S_SGL  = 3'b100
  } st_t;
  st_t st_q, st_d;
  logic [9:0] addr_q;
  logic [7:0] wdata_q, rbuf_q, sts_q, mask_q, rdata_q;
  logic       poll_q;
  logic       sgl_we_q;  // single access is a write
  logic       sgl_rd_q;  // single read data arrives this cycle

  // command bits: 0 power down chan B seq, 1 single access (write if wdata bit0 set, else read), 2 single read
  wire cmd_wr = WR & (ADDR == HOST_CMD);
  wire busy   = st_q != S_IDLE;
  wire go_seq = cmd_wr & WDATA[0] & ~busy;
  wire go_wr  = cmd_wr & WDATA[1] & ~busy & ~WDATA[0];
  wire go_rd  = cmd_wr & WDATA[2] & ~busy & ~WDATA[0] & ~WDATA[1];
  wire cal_done = poll_q & (LINK.rdata == 8'h00);
  wire ev_done  = (st_q == S_SGL) | cal_done;
  wire ev_seq   = cal_done;

  // state sequence
  always_comb
  begin
    case (st_q)
      S_IDLE:  st_d = go_seq ? S_IDXB : (go_wr | go_rd) ? S_SGL : S_IDLE;
      S_IDXB:  st_d = S_PWDN;
      S_PWDN:  st_d = S_IDXA;
      S_IDXA:  st_d = S_RST;
      S_RST:   st_d = S_NORM;
      S_NORM:  st_d = S_POLL;
      S_POLL:  st_d = cal_done ? S_IDLE : S_POLL;
      S_SGL:   st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  // link drive per state
  always_comb
  begin
    LINK.req   = 1'b1;
    LINK.we    = 1'b1;
    LINK.addr  = OFS_CHAN_INDEX;
    LINK.wdata = IDX_CHAN_B;
    case (st_q)
      S_IDXB:  ;
      S_PWDN:  begin LINK.addr = OFS_CHAN_STATUS; LINK.wdata = CS_PWDN_VAL; end
      S_IDXA:  LINK.wdata = IDX_CLK_A;
      S_RST:   begin LINK.addr = OFS_POWER_MODE; LINK.wdata = PM_RST_VAL; end
      S_NORM:  begin LINK.addr = OFS_POWER_MODE; LINK.wdata = 8'h00; end
      S_POLL:  begin LINK.we = 1'b0; LINK.addr = OFS_CAL_STATUS; LINK.req = ~poll_q; end
      S_SGL:   begin LINK.we = sgl_we_q; LINK.addr = addr_q; LINK.wdata = wdata_q; end
      default: LINK.req = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_q     <= S_IDLE;
      poll_q   <= 1'b0;
      sgl_rd_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      poll_q <= LINK.req & ~LINK.we & (st_q == S_POLL);
      // link read data stands one cycle after the read request
      sgl_rd_q <= (st_q == S_SGL) & ~sgl_we_q;
    end
  end

  // host registers
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      addr_q  <= 10'h000;
      wdata_q <= 8'h00;
      mask_q  <= 8'h00;
      sts_q   <= 8'h00;
      rbuf_q  <= 8'h00;
      sgl_we_q <= 1'b0;
    end
    else
    begin
      if (WR && ADDR == HOST_ADDR)  addr_q  <= {2'b00, WDATA};
      if (WR && ADDR == HOST_WDATA) wdata_q <= WDATA;
      if (WR && ADDR == HOST_MASK)  mask_q  <= WDATA;
      // single read command never writes; single access writes when wdata bit0 set
      if (go_wr | go_rd) sgl_we_q <= go_wr & wdata_q[0];
      if (sgl_rd_q) rbuf_q <= LINK.rdata;
      // set wins over write-one-to-clear
      sts_q <= (sts_q & ~((WR && ADDR == HOST_IRQ) ? WDATA : 8'h00))
             | {6'h00, ev_seq, ev_done};
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      rdata_q <= 8'h00;
    else if (RD)
      case (ADDR)
        HOST_STATUS: rdata_q <= {7'h00, busy};
        HOST_IRQ:    rdata_q <= sts_q;
        HOST_MASK:   rdata_q <= mask_q;
        HOST_RDATA:  rdata_q <= rbuf_q;
        HOST_ADDR:   rdata_q <= addr_q[7:0];
        HOST_WDATA:  rdata_q <= wdata_q;
        default:     rdata_q <= 8'h00;
      endcase
  end
  assign RDATA = rdata_q;
  assign IRQ   = |(sts_q & mask_q);
endmodule // cfg_ctrl
`default_nettype wire

// ### sim/cfg_link_sva.sv
// assertion checker for the register link and the bank outputs
`default_nettype none
module cfg_link_sva
  import cfg_pkg::*;
(
  input wire logic       CORE_CLK,      // clock
  input wire logic       RST_B,         // async reset, active low
  input wire logic       req,           // access strobe
  input wire logic       we,            // write when high
  input wire logic [9:0] addr,          // register offset
  input wire logic [7:0] wdata,         // write data
  input wire logic [7:0] rdata,         // read data
  input wire logic [2:0] SER_MODE,      // serialization mode
  input wire logic [1:0] CHAN_PWDN,     // channel power-down
  input wire logic [1:0] CLK_ORST,      // clock output reset
  input wire logic       RECOVERY_EN,   // recovery active
  input wire logic       REF_DRIVE_EXT, // external reference drive
  input wire logic [1:0] REF_LEVEL,     // reference level
  input wire logic [1:0] POWER_MODE,    // power mode
  input wire logic       CAL_BUSY       // calibration running
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL_MAX = 80;
  logic [7:0] idx_q;
  wire        wr_w = req && we;
  // mirror of the channel index
  always_ff @(posedge CORE_CLK or negedge RST_B)
    if (!RST_B)
      idx_q <= RST_CHAN_INDEX;
    else if (wr_w && addr == OFS_CHAN_INDEX)
      idx_q <= wdata;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_SER_MODE: assert property (wr_w && addr == OFS_SER_OUT_CTL
    |=> SER_MODE == $past(wdata[6:4])) else $error("serial mode not taken");
  AST_RECOVERY: assert property (wr_w && addr == OFS_CLK_MON_CTL
    |=> RECOVERY_EN == ($past(wdata[5:3]) == RECOVERY_ON)) else $error("recovery wrong");
  AST_REF_CTL: assert property (wr_w && addr == OFS_REF_CTL
    |=> {REF_DRIVE_EXT, REF_LEVEL} == $past(wdata[2:0])) else $error("reference wrong");
  AST_PWR_MODE: assert property (wr_w && addr == OFS_POWER_MODE
    |=> POWER_MODE == $past(wdata[1:0])) else $error("power mode wrong");
  AST_DIG_RST: assert property (wr_w && addr == OFS_POWER_MODE && wdata[1:0] == PM_DIG_RST
    |=> CAL_BUSY [*8]) else $error("no calibration after digital reset");
  AST_CAL_END: assert property ($rose(CAL_BUSY) |-> ##[1:CAL_MAX] !CAL_BUSY)
    else $error("calibration never ends");
  AST_CAL_READ: assert property (req && !we && addr == OFS_CAL_STATUS && !CAL_BUSY
    |=> rdata == 8'h00) else $error("calibration status not zero");
  AST_DEFAULTS: assert property ($rose(RST_B) |-> SER_MODE == 3'h3 && !RECOVERY_EN
    && !REF_DRIVE_EXT && REF_LEVEL == 2'h0 && CHAN_PWDN == 2'h0) else $error("bad defaults");
  AST_CHAN_B: assert property (wr_w && addr == OFS_CHAN_STATUS && idx_q[1]
    |=> CHAN_PWDN[1] == $past(wdata[CS_PWDN_BIT])) else $error("channel b not written");
  AST_CHAN_KEEP: assert property (wr_w && addr == OFS_CHAN_STATUS && !idx_q[1]
    |=> $stable(CHAN_PWDN[1])) else $error("unselected channel changed");
  AST_CLK_TGT: assert property (wr_w && addr == OFS_CHAN_STATUS && idx_q[IDX_DCO_BIT]
    |=> CLK_ORST[1] == $past(wdata[CS_ORST_BIT])) else $error("data clock not written");
  // main scenarios
  cover property (wr_w && addr == OFS_CHAN_STATUS && idx_q == IDX_CHAN_B);
  cover property ($fell(CAL_BUSY));
  cover property (wr_w && addr == OFS_CLK_MON_CTL && wdata[5:3] == RECOVERY_ON);
endmodule // cfg_link_sva
`default_nettype wire

// ### sim/adc_output_config_registers_tb.sv
// self-checking testbench for controller and register bank
`default_nettype none
module adc_output_config_registers_tb
  import cfg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_b, tb_sel, t_req, t_we, h_wr, h_rd, irq;
  logic [9:0] t_addr;
  logic [7:0] t_wdata, h_wdata, h_rdata, rd_v;
  logic [3:0] h_addr;
  logic [2:0] ser_mode;
  logic [1:0] pwdn, orst, corst, ref_lvl, pmode;
  logic       rec_en, ref_ext, cal_busy;
  int         error_cnt, samples_checked;
  localparam logic [9:0] DEF_A [6] = '{OFS_SER_OUT_CTL, OFS_CHAN_STATUS, OFS_USER_IO_TWO,
                                       OFS_USER_IO_THR, OFS_CLK_MON_CTL, OFS_REF_CTL};
  localparam logic [7:0] DEF_V [6] = '{RST_SER_OUT_CTL, RST_CHAN_STATUS, RST_USER_IO,
                                       RST_USER_IO, RST_CLK_MON_CTL, RST_REF_CTL};
  cfg_if link_if ();
  cfg_if bus_if ();
  // bench or controller drives the bank
  assign bus_if.req     = tb_sel ? t_req : link_if.req;
  assign bus_if.we      = tb_sel ? t_we : link_if.we;
  assign bus_if.addr    = tb_sel ? t_addr : link_if.addr;
  assign bus_if.wdata   = tb_sel ? t_wdata : link_if.wdata;
  assign link_if.rdata  = bus_if.rdata;
  cfg_regbank u_cfg_regbank (.CORE_CLK(clk), .RST_B(rst_b), .BUS(bus_if.dev),
    .SER_MODE(ser_mode), .CHAN_PWDN(pwdn), .CHAN_ORST(orst), .CLK_ORST(corst),
    .RECOVERY_EN(rec_en), .REF_DRIVE_EXT(ref_ext), .REF_LEVEL(ref_lvl),
    .POWER_MODE(pmode), .CAL_BUSY(cal_busy));
  cfg_ctrl u_cfg_ctrl (.CORE_CLK(clk), .RST_B(rst_b), .ADDR(h_addr), .WDATA(h_wdata),
    .WR(h_wr), .RD(h_rd), .RDATA(h_rdata), .IRQ(irq), .LINK(link_if.ctrl));
  cfg_link_sva u_cfg_link_sva (.CORE_CLK(clk), .RST_B(rst_b), .req(bus_if.req),
    .we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .SER_MODE(ser_mode), .CHAN_PWDN(pwdn), .CLK_ORST(corst), .RECOVERY_EN(rec_en),
    .REF_DRIVE_EXT(ref_ext), .REF_LEVEL(ref_lvl), .POWER_MODE(pmode), .CAL_BUSY(cal_busy));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic lacc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    t_req   <= 1'b1;
    t_we    <= w;
    t_addr  <= a;
    t_wdata <= d;
    @(posedge clk);
    t_req <= 1'b0;
    #1;
  endtask
  task automatic hacc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    h_wr    <= w;
    h_rd    <= !w;
    h_addr  <= a;
    h_wdata <= d;
    @(posedge clk);
    h_wr <= 1'b0;
    h_rd <= 1'b0;
    #1;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    {rst_b, t_req, t_we, h_wr, h_rd, t_addr, t_wdata, h_addr, h_wdata} = '0;
    {error_cnt, samples_checked} = '0;
    tb_sel = 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      lacc(1'b0, DEF_A[i], 8'h00);
      chk("default", DEF_V[i], bus_if.rdata);
    end
    $display("test defaults done");
    for (int m = 0; m < 5; m++)
    begin
      lacc(1'b1, OFS_SER_OUT_CTL, 8'(m << 4));
      chk("ser_mode", 8'(m), {5'h0, ser_mode});
    end
    lacc(1'b1, OFS_CLK_MON_CTL, 8'h2f);
    chk("recovery_on", 8'h01, {7'h0, rec_en});
    lacc(1'b1, OFS_CLK_MON_CTL, 8'h07);
    chk("recovery_off", 8'h00, {7'h0, rec_en});
    lacc(1'b1, OFS_REF_CTL, 8'h07);
    chk("reference", 8'h07, {5'h0, ref_ext, ref_lvl});
    $display("test fields done");
    // let power-up calibration finish so the digital reset shows on its own
    for (int i = 0; i < 200 && cal_busy !== 1'b0; i++) @(posedge clk);
    chk("powerup_cal", 8'h00, {7'h0, cal_busy});
    for (int p = 0; p < 4; p++)
    begin
      lacc(1'b1, OFS_POWER_MODE, 8'(p));
      chk("power_mode", 8'(p), {6'h0, pmode});
    end
    chk("cal_busy", 8'h01, {7'h0, cal_busy});
    lacc(1'b1, OFS_POWER_MODE, 8'h00);
    for (int i = 0; i < 200 && cal_busy !== 1'b0; i++) @(posedge clk);
    lacc(1'b1, OFS_CAL_STATUS, 8'hff);
    lacc(1'b0, OFS_CAL_STATUS, 8'h00);
    chk("cal_status", 8'h00, bus_if.rdata);
    $display("test power and calibration done");
    lacc(1'b1, OFS_CHAN_INDEX, 8'h01);
    lacc(1'b1, OFS_CHAN_STATUS, 8'h04);
    chk("chan_orst", 8'h01, {6'h0, orst});
    chk("clk_orst", 8'h00, {6'h0, corst});
    lacc(1'b1, OFS_SER_OUT_CTL, 8'h10);
    chk("global_ser", 8'h01, {5'h0, ser_mode});
    @(posedge clk);
    tb_sel <= 1'b0;
    hacc(1'b1, HOST_MASK, 8'h00);
    hacc(1'b1, HOST_CMD, 8'h01);
    for (int i = 0; i < 100; i++)
    begin
      hacc(1'b0, HOST_STATUS, 8'h00);
      if (h_rdata[0] === 1'b0)
        break;
    end
    chk("chan_pwdn", 8'h02, {6'h0, pwdn});
    chk("pmode_after", 8'h00, {6'h0, pmode});
    hacc(1'b0, HOST_IRQ, 8'h00);
    chk("irq_status", 8'h03, h_rdata);
    chk("irq_masked", 8'h00, {7'h0, irq});
    hacc(1'b1, HOST_MASK, 8'h03);
    @(posedge clk);
    #1;
    chk("irq_on", 8'h01, {7'h0, irq});
    hacc(1'b1, HOST_IRQ, 8'h03);
    @(posedge clk);
    #1;
    chk("irq_clear", 8'h00, {7'h0, irq});
    hacc(1'b1, HOST_ADDR, 8'h21);
    hacc(1'b1, HOST_WDATA, 8'h41);
    hacc(1'b1, HOST_CMD, 8'h02);
    @(posedge clk);
    #1;
    chk("host_write", 8'h04, {5'h0, ser_mode});
    hacc(1'b1, HOST_CMD, 8'h04);
    @(posedge clk);
    hacc(1'b0, HOST_RDATA, 8'h00);
    chk("host_read", 8'h41, h_rdata);
    hacc(1'b0, HOST_IRQ, 8'h00);
    chk("host_done", 8'h01, h_rdata);
    @(posedge clk);
    tb_sel <= 1'b1;
    lacc(1'b1, OFS_CHAN_STATUS, 8'h04);
    chk("clk_targets", 8'h03, {6'h0, corst});
    chk("b_kept", 8'h02, {6'h0, pwdn});
    $display("test sequence done");
    final_report();
  end
endmodule // adc_output_config_registers_tb
`default_nettype wire
